// [drfla_regfile.v]
// Integer and floating-point register files with load path and interlock
`timescale 1ns/10ps
`include "drfla_consts.vh"
module drfla_regfile (
  input wire clk,
  input wire reset_n,
  input wire [4:0] int_ra,
  input wire [4:0] int_rb,
  output wire [31:0] int_da,
  output wire [31:0] int_db,
  input wire int_we,
  input wire [4:0] int_wa,
  input wire [31:0] int_wd,
  input wire [4:0] fp_ra,
  input wire [4:0] fp_rb,
  input wire fp_rd_dbl,
  output wire [63:0] fp_da,
  output wire [63:0] fp_db,
  input wire fp_we,
  input wire fp_wr_dbl,
  input wire [4:0] fp_wa,
  input wire [63:0] fp_wd,
  input wire ld_valid,
  input wire ld_to_fp,
  input wire [2:0] ld_size,
  input wire ld_sign_ext,
  input wire [31:0] ld_addr,
  input wire [4:0] ld_dest,
  input wire [127:0] ld_data,
  output reg ld_trap,
  input wire int_issue,
  input wire [4:0] int_issue_dest,
  input wire fp_issue,
  input wire fp_issue_dbl,
  input wire [4:0] fp_issue_dest,
  input wire int_retire,
  input wire [4:0] int_retire_dest,
  input wire fp_retire,
  input wire fp_retire_dbl,
  input wire [4:0] fp_retire_dest,
  output wire int_stall,
  output wire fp_stall
);
  reg [31:0] int_mem [0:`DRFLA_NREGS-1];
  reg [31:0] fp_mem [0:`DRFLA_NREGS-1];
  reg [31:0] int_pend_q;
  reg [31:0] fp_pend_q;
  wire [127:0] aligned;
  wire misaligned;
  wire [4:0] fra_e;
  wire [4:0] frb_e;
  wire [4:0] fwa_e;
  wire [4:0] lq_base;
  wire ld_ok;

  wire ld_int_wr;
  wire fp_pair_wr;
  wire fp_word_wr;
  wire ld_trap_d;

  wire fp_a_pend;
  wire fp_b_pend;
  wire [31:0] int_pend_d;
  wire [31:0] fp_pend_d;

  wire [9:0] int_raddr;
  wire [9:0] fp_raddr;
  wire [63:0] int_rdata;
  wire [127:0] fp_rdata;

  // Alignment is combinational so a trap and a suppressed write share a cycle
  drfla_align u_align (
    .size(ld_size),
    .addr_lo(ld_addr[3:0]),
    .sign_ext(ld_sign_ext),
    .mem_data(ld_data),
    .aligned(aligned),
    .misaligned(misaligned)
  );

  assign ld_ok = ld_valid & ~misaligned;
  // Pair addresses force the low bit to the even half
  assign fra_e = {fp_ra[4:1], 1'b0};
  assign frb_e = {fp_rb[4:1], 1'b0};
  assign fwa_e = {fp_wa[4:1], 1'b0};
  // Quad loads ignore the low two destination bits
  assign lq_base = {ld_dest[4:2], 2'b00};

  // Write decodes; zero destinations are filtered before storage
  assign ld_int_wr = ld_ok & ~ld_to_fp & (ld_dest != `DRFLA_INT_ZERO);
  assign fp_pair_wr = fp_we & fp_wr_dbl & (fwa_e != `DRFLA_FP_ZERO_LO);
  assign fp_word_wr = fp_we & ~fp_wr_dbl & (fp_wa > `DRFLA_FP_ZERO_HI);
  // Trap is raised even for a dropped destination, the access itself is bad
  assign ld_trap_d = ld_valid & misaligned;

  // Both read ports share one body so they cannot drift apart
  assign int_raddr = {int_rb, int_ra};
  assign fp_raddr = {fp_rb, fp_ra};
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_rd
      wire [4:0] ia = int_raddr[p*5 +: 5];
      wire [4:0] fa = fp_raddr[p*5 +: 5];
      wire [4:0] fe = {fa[4:1], 1'b0};
      // Zero registers are masked here, their storage may hold anything
      wire [31:0] i_word = (ia == `DRFLA_INT_ZERO) ? 32'h00000000 : int_mem[ia];
      wire [31:0] f_word = (fa <= `DRFLA_FP_ZERO_HI) ? 32'h00000000 : fp_mem[fa];
      // Pair 0 is both hardwired zero registers
      wire [31:0] f_even = (fe == `DRFLA_FP_ZERO_LO) ? 32'h00000000 : fp_mem[fe];
      wire [31:0] f_odd = (fe == `DRFLA_FP_ZERO_LO) ? 32'h00000000 : fp_mem[fe | 5'h01];
      assign int_rdata[p*32 +: 32] = i_word;
      // Pairs read high word from odd register
      assign fp_rdata[p*64 +: 64] = fp_rd_dbl ? {f_odd, f_even} : {32'h00000000, f_word};
    end
  endgenerate
  assign int_da = int_rdata[31:0];
  assign int_db = int_rdata[63:32];
  assign fp_da = fp_rdata[63:0];
  assign fp_db = fp_rdata[127:64];

  // Pending writes: a read of any pending register stalls
  assign int_stall = int_pend_q[int_ra] | int_pend_q[int_rb];
  // A pair read waits on either half of the pair
  assign fp_a_pend = fp_rd_dbl ? (fp_pend_q[fra_e] | fp_pend_q[fra_e | 5'h01]) : fp_pend_q[fp_ra];
  assign fp_b_pend = fp_rd_dbl ? (fp_pend_q[frb_e] | fp_pend_q[frb_e | 5'h01]) : fp_pend_q[fp_rb];
  assign fp_stall = fp_a_pend | fp_b_pend;

  // Scoreboard; set on issue wins over retire of same register
  genvar g;
  generate
    for (g = 0; g < `DRFLA_NREGS; g = g + 1) begin : g_sb
      wire is_i = int_issue && int_issue_dest == g && g != 0;
      wire rt_i = int_retire && int_retire_dest == g;
      wire is_f = fp_issue && g > 1 && (fp_issue_dbl ? (fp_issue_dest[4:1] == g / 2) : (fp_issue_dest == g));
      wire rt_f = fp_retire && (fp_retire_dbl ? (fp_retire_dest[4:1] == g / 2) : (fp_retire_dest == g));
      assign int_pend_d[g] = is_i | (int_pend_q[g] & ~rt_i);
      assign fp_pend_d[g] = is_f | (fp_pend_q[g] & ~rt_f);
    end
  endgenerate

  // Cleared on reset so nothing stalls before the first issue
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_pend_q <= 32'h00000000;
      fp_pend_q <= 32'h00000000;
    end else begin
      int_pend_q <= int_pend_d;
      fp_pend_q <= fp_pend_d;
    end
  end

  // Storage carries no reset; zero registers are masked at read
  always @(posedge clk) begin
    if (int_we && int_wa != `DRFLA_INT_ZERO) begin
      int_mem[int_wa] <= int_wd;
    end
    // Load path is the only way memory data reaches the files
    // Placed after the port write so a same-register load wins
    if (ld_int_wr) begin
      int_mem[ld_dest] <= aligned[31:0];
    end
  end

  always @(posedge clk) begin
    if (fp_pair_wr) begin
      fp_mem[fwa_e] <= fp_wd[31:0];
      fp_mem[fwa_e | 5'h01] <= fp_wd[63:32];
    end
    if (fp_word_wr) begin
      fp_mem[fp_wa] <= fp_wd[31:0];
    end
    // Load is applied last so it wins a same-register collision
    if (ld_ok && ld_to_fp) begin
      case (ld_size)
        `DRFLA_SZ_128: begin
          // Quad into pair 0 still fills base+2 and base+3
          if (lq_base != `DRFLA_FP_ZERO_LO) begin
            fp_mem[lq_base] <= aligned[31:0];
            fp_mem[lq_base | 5'h01] <= aligned[63:32];
          end
          fp_mem[lq_base | 5'h02] <= aligned[95:64];
          fp_mem[lq_base | 5'h03] <= aligned[127:96];
        end
        `DRFLA_SZ_64: begin
          if (ld_dest[4:1] != 4'h0) begin
            fp_mem[{ld_dest[4:1], 1'b0}] <= aligned[31:0];
            fp_mem[{ld_dest[4:1], 1'b1}] <= aligned[63:32];
          end
        end
        default: begin
          if (ld_dest > `DRFLA_FP_ZERO_HI) begin
            fp_mem[ld_dest] <= aligned[31:0];
          end
        end
      endcase
    end
  end

  // Registered so the trap pulse lands in the cycle after the load
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_trap <= 1'b0;
    end else begin
      ld_trap <= ld_trap_d;
    end
  end
endmodule // drfla_regfile

// [drfla_consts.vh]
// Constants for the dual register file with load alignment
`ifndef DRFLA_CONSTS_VH
`define DRFLA_CONSTS_VH
`define DRFLA_NREGS 32
`define DRFLA_AW 5
`define DRFLA_DW 32
`define DRFLA_INT_ZERO 5'h00
`define DRFLA_FP_ZERO_LO 5'h00
`define DRFLA_FP_ZERO_HI 5'h01
`define DRFLA_SZ_8 3'h0
`define DRFLA_SZ_16 3'h1
`define DRFLA_SZ_32 3'h2
`define DRFLA_SZ_64 3'h3
`define DRFLA_SZ_128 3'h4
`define DRFLA_RESET_VAL 32'h00000000
`endif

// [drfla_align.v]
// Load data alignment and misalignment detection
`timescale 1ns/10ps
`include "drfla_consts.vh"
module drfla_align (
  input wire [2:0] size,
  input wire [3:0] addr_lo,
  input wire sign_ext,
  input wire [127:0] mem_data,
  output reg [127:0] aligned,
  output reg misaligned
);
  reg [31:0] word;
  always @* begin
    word = mem_data[31:0];
    aligned = mem_data;
    misaligned = 1'b0;
    case (size)
      `DRFLA_SZ_8: begin
        word = mem_data[31:0] >> {addr_lo[1:0], 3'b000};
        aligned = {96'h0, (sign_ext ? {{24{word[7]}}, word[7:0]} : {24'h0, word[7:0]})};
      end
      `DRFLA_SZ_16: begin
        misaligned = addr_lo[0];
        word = mem_data[31:0] >> {addr_lo[1], 4'b0000};
        aligned = {96'h0, (sign_ext ? {{16{word[15]}}, word[15:0]} : {16'h0, word[15:0]})};
      end
      `DRFLA_SZ_32: misaligned = |addr_lo[1:0];
      `DRFLA_SZ_64: misaligned = |addr_lo[2:0];
      `DRFLA_SZ_128: misaligned = |addr_lo[3:0];
      default: misaligned = 1'b1;
    endcase
  end
endmodule // drfla_align

// [drfla_sva.sv]
// Port assertions for the register file
`timescale 1ns/10ps
module drfla_sva (
  input wire clk,
  input wire reset_n,
  input wire [4:0] int_ra,
  input wire [31:0] int_da,
  input wire int_we,
  input wire [4:0] int_wa,
  input wire [31:0] int_wd,
  input wire [4:0] fp_ra,
  input wire fp_rd_dbl,
  input wire [63:0] fp_da,
  input wire ld_valid,
  input wire [2:0] ld_size,
  input wire [31:0] ld_addr,
  input wire ld_trap,
  input wire int_issue,
  input wire [4:0] int_issue_dest,
  input wire int_stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Size 4 wraps the shift to zero, giving the full quad mask
  wire [3:0] m = (4'h1 << ld_size) - 4'h1;
  wire bad = |(ld_addr[3:0] & m) || ld_size > 3'h4;
  sequence s_wr; int_we && int_wa != 0 && !ld_valid; endsequence
  sequence s_iss; int_issue && int_issue_dest != 0; endsequence
  a_int_zero: assert property (int_ra == 0 |-> int_da == 0) else $error("r zero");
  a_fp_zero: assert property (fp_ra[4:1] == 0 |-> fp_da == 0) else $error("f zero");
  a_fp_single: assert property (!fp_rd_dbl |-> fp_da[63:32] == 0) else $error("single");
  a_trap_load: assert property (ld_valid |=> ld_trap == $past(bad)) else $error("trap");
  a_trap_idle: assert property (!ld_valid |=> !ld_trap) else $error("idle trap");
  a_int_write: assert property (s_wr ##1 int_ra == $past(int_wa) |-> int_da == $past(int_wd))
    else $error("write");
  a_int_stall: assert property (s_iss ##1 int_ra == $past(int_issue_dest) |-> int_stall)
    else $error("stall");
  a_int_hold: assert property ($stable(int_ra) && !$past(int_we) && !$past(ld_valid) |-> $stable(int_da))
    else $error("hold");
endmodule // drfla_sva
bind drfla_regfile drfla_sva chk (.*);

// [drfla_lsu_model.sv]
// Load pipeline model feeding memory data
`timescale 1ns/10ps
module drfla_lsu_model (
  input wire clk,
  output bit ld_valid,
  output bit ld_to_fp,
  output bit [2:0] ld_size,
  output bit ld_sign_ext,
  output bit [31:0] ld_addr,
  output bit [4:0] ld_dest,
  output bit [127:0] ld_data
);
  task ld(input f, input [2:0] s, input x, input [31:0] a, input [4:0] d, input [127:0] v);
    @(negedge clk);
    {ld_valid, ld_to_fp, ld_size, ld_sign_ext, ld_addr, ld_dest, ld_data} = {1'b1, f, s, x, a, d, v};
    @(negedge clk);
    ld_valid = 0;
    // Stale lines flipped so the design cannot lean on them
    {ld_addr, ld_data} = ~{a, v};
  endtask
endmodule // drfla_lsu_model

// [drfla_tb.sv]
// Self-checking bench for the register file
`timescale 1ns/10ps
module testbench;
  bit clk, reset_n, int_we, fp_we, fp_wr_dbl, fp_rd_dbl, int_issue, fp_issue, fp_issue_dbl;
  bit int_retire, fp_retire, fp_retire_dbl;
  bit [4:0] int_ra, int_rb, int_wa, fp_ra, fp_rb, fp_wa;
  bit [4:0] int_issue_dest, fp_issue_dest, int_retire_dest, fp_retire_dest;
  bit [31:0] int_wd;
  bit [63:0] fp_wd;
  wire [31:0] int_da, int_db, ld_addr;
  wire [63:0] fp_da, fp_db;
  wire [127:0] ld_data;
  wire [4:0] ld_dest;
  wire [2:0] ld_size;
  wire ld_valid, ld_to_fp, ld_sign_ext, ld_trap, int_stall, fp_stall;
  int fails, n_tests;
  localparam bit [127:0] QW = 128'h0f0e0d0c_0b0a0908_07060504_a5b6c7d8;
  drfla_regfile dut (.*);
  drfla_lsu_model lsu (.*);
  initial forever #10 clk = ~clk;
  task chk(input string n, input [127:0] e, input [127:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function bit [31:0] ev(bit [4:0] j);
    return j ? 32'h5a000000 + j : 0;
  endfunction
  task t_int;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      {int_we, int_wa, int_wd} = {1'b1, i[4:0], 32'h5a000000 + i};
    end
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      {int_we, int_ra, int_rb} = {1'b0, i[4:0], 5'd31 - i[4:0]};
      #1 chk("int_da", ev(i), int_da);
      chk("int_db", ev(31 - i), int_db);
    end
    $display("t_int end");
  endtask
  task wf(input [4:0] a, input [63:0] d, input b);
    @(negedge clk);
    {fp_we, fp_wr_dbl, fp_wa, fp_wd} = {1'b1, b, a, d};
    @(negedge clk);
    fp_we = 0;
  endtask
  task t_fp;
    wf(5'd4, 64'h11112222_33334444, 1);
    wf(5'd0, '1, 1);
    wf(5'd1, 64'h12345678, 0);
    {fp_rd_dbl, fp_ra, fp_rb} = {1'b1, 5'd4, 5'd0};
    #1 chk("fp_da", 64'h11112222_33334444, fp_da);
    chk("fp_db", 0, fp_db);
    {fp_rd_dbl, fp_ra, fp_rb} = {1'b0, 5'd5, 5'd1};
    #1 chk("fp_da", 32'h11112222, fp_da);
    chk("fp_db", 0, fp_db);
    $display("t_fp end");
  endtask
  task t_load;
    lsu.ld(1, 3'h4, 0, 32'h100, 5'd8, QW);
    #1 chk("ld_trap", 0, ld_trap);
    lsu.ld(0, 3'h0, 0, 32'h1, 5'd5, QW);
    lsu.ld(0, 3'h1, 1, 32'h2, 5'd6, QW);
    lsu.ld(0, 3'h2, 0, 32'h2, 5'd7, QW);
    #1 chk("ld_trap", 1, ld_trap);
    {fp_rd_dbl, fp_ra, fp_rb, int_ra, int_rb} = {1'b1, 5'd8, 5'd10, 5'd5, 5'd6};
    #1 chk("fp_da", QW[63:0], fp_da);
    chk("fp_db", QW[127:64], fp_db);
    chk("int_da", 32'hc7, int_da);
    chk("int_db", 32'hffffa5b6, int_db);
    int_ra = 7;
    #1 chk("int_da", ev(7), int_da);
    $display("t_load end");
  endtask
  task t_stall;
    @(negedge clk);
    {int_issue, int_issue_dest, fp_issue, fp_issue_dest} = {1'b1, 5'd3, 1'b1, 5'd6};
    @(negedge clk);
    {int_issue, fp_issue, int_ra, fp_ra, fp_rd_dbl} = {2'b0, 5'd3, 5'd6, 1'b0};
    #1 chk("stall", 2'b11, {int_stall, fp_stall});
    @(negedge clk);
    {int_retire, int_retire_dest, fp_retire, fp_retire_dest} = {1'b1, 5'd3, 1'b1, 5'd6};
    @(negedge clk);
    {int_retire, fp_retire} = 2'b0;
    #1 chk("stall", 0, {int_stall, fp_stall});
    $display("t_stall end");
  endtask
  task t_more;
    lsu.ld(1, 3'h3, 0, 32'h108, 5'd13, QW);
    lsu.ld(0, 3'h0, 1, 32'h3, 5'd9, QW);
    lsu.ld(1, 3'h2, 0, 32'h4, 5'd14, QW);
    lsu.ld(1, 3'h4, 0, 32'h0, 5'd1, QW);
    lsu.ld(1, 3'h3, 0, 32'h104, 5'd12, ~QW);
    #1 chk("ld_trap", 1, ld_trap);
    @(negedge clk);
    {fp_rd_dbl, fp_ra, fp_rb, int_ra} = {1'b1, 5'd12, 5'd2, 5'd9};
    #1 chk("ld_trap", 0, ld_trap);
    chk("fp_da", QW[63:0], fp_da);
    chk("fp_db", QW[127:64], fp_db);
    chk("int_da", 32'hffffffa5, int_da);
    {fp_rd_dbl, fp_ra, fp_rb} = {1'b0, 5'd1, 5'd14};
    #1 chk("fp_da", 0, fp_da);
    chk("fp_db", 32'ha5b6c7d8, fp_db);
    @(negedge clk);
    {fp_issue, fp_issue_dbl, fp_issue_dest, fp_ra, fp_rb} = {2'b11, 5'd21, 5'd20, 5'd2};
    @(negedge clk);
    {fp_issue, fp_issue_dbl, fp_retire, fp_retire_dbl, fp_retire_dest} = {4'b0011, 5'd20};
    {int_issue, int_issue_dest, int_retire, int_retire_dest, int_ra} = {1'b1, 5'd4, 1'b1, 5'd4, 5'd4};
    #1 chk("fp_stall", 1, fp_stall);
    @(negedge clk);
    {int_issue, fp_retire, fp_retire_dbl} = 3'b0;
    #1 chk("stall", 2'b10, {int_stall, fp_stall});
    @(negedge clk);
    int_retire = 0;
    #1 chk("int_stall", 0, int_stall);
    $display("t_more end");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1;
    t_int;
    t_fp;
    t_load;
    t_stall;
    t_more;
    tally_and_finish;
  end
  // Whole run is about a hundred cycles
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
endmodule // testbench
